// file: core/tasp_pkg.sv
package tasp_pkg;
  // ----------------------------------------
  // Axis indices
  // ----------------------------------------
  localparam int TASP_AXIS_X = 0;
  localparam int TASP_AXIS_Y = 1;
  localparam int TASP_AXIS_Z = 2;
  localparam int TASP_NUM_AXES = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic TASP_RUN_RST = 1'h0;
  localparam logic TASP_FLAG_RST = 1'h0;
  localparam logic TASP_DIR_PRESET = 1'h1;
  // ----------------------------------------
  // Scan orders
  // ----------------------------------------
  typedef enum {
    TASP_ORDER_NONE,
    TASP_ORDER_XFIRST,
    TASP_ORDER_ZFIRST
  } tasp_order_t;
endpackage

// file: core/tasp_axis_if.sv
`timescale 1ns/1ns
interface tasp_axis_if;
  logic set_lower;
  logic set_upper;
  logic toggle_dir;
  logic clear_run;
  logic preset_dir;
  logic lower_q;
  logic upper_q;
  logic dir_q;
  logic enable;
  modport ctrl (
    output set_lower,
    output set_upper,
    output toggle_dir,
    output clear_run,
    output preset_dir,
    input lower_q,
    input upper_q,
    input dir_q,
    input enable
  );
  modport axis (
    input set_lower,
    input set_upper,
    input toggle_dir,
    input clear_run,
    input preset_dir,
    output lower_q,
    output upper_q,
    output dir_q,
    output enable
  );
endinterface

// file: core/tasp_axis.sv
`timescale 1ns/1ns
module tasp_axis
  import tasp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Step strobe
  input wire logic i_step,
  // Control
  tasp_axis_if.axis ax
);
  logic lower_q, lower_d;
  logic upper_q, upper_d;
  logic dir_q, dir_d;

  // ----------------------------------------
  // Run and direction triplet
  // ----------------------------------------
  always_comb begin
    lower_d = lower_q;
    upper_d = upper_q;
    dir_d = dir_q;
    if (ax.preset_dir) begin
      dir_d = TASP_DIR_PRESET;
    end else if (i_step && ax.toggle_dir) begin
      dir_d = ~dir_q;
    end
    // This axis' own set on a step beats a clear from other axes; one run at a time
    if (ax.clear_run) begin
      lower_d = TASP_RUN_RST;
      upper_d = TASP_RUN_RST;
    end
    if (i_step) begin
      // Set lands on the lower or upper run by the direction it leaves
      lower_d = ax.set_lower;
      upper_d = ax.set_upper;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lower_q <= TASP_RUN_RST;
      upper_q <= TASP_RUN_RST;
      dir_q <= TASP_DIR_PRESET;
    end else begin
      lower_q <= lower_d;
      upper_q <= upper_d;
      dir_q <= dir_d;
    end
  end

  assign ax.lower_q = lower_q;
  assign ax.upper_q = upper_q;
  assign ax.dir_q = dir_q;
  assign ax.enable = lower_q | upper_q;
endmodule

// file: core/tasp_edge.sv
`timescale 1ns/1ns
module tasp_edge (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pin level in, rising-edge pulse out
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise
);
  logic s1_q, s1_d;
  logic s2_q, s2_d;
  logic s3_q, s3_d;

  // ----------------------------------------
  // Two-flop synchroniser and edge detect
  // ----------------------------------------
  always_comb begin
    s1_d = i_pin;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
      s3_q <= 1'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign o_level = s2_q;
  assign o_rise = s2_q & ~s3_q;
endmodule

// file: core/tasp_programmer.sv
`timescale 1ns/1ns
// Summary of operation
// - X-first: enable X every dwell end unless matched or Z is running
// - X-first X match: flip X, enable Y
// - X-first Y unmatched: back to X
// - X-first Y match: flip Y, row flag, X
// - X-first match with row flag: enable Z
// - X-first Z done: X again, clear row flag
// - X-first Z upper match: set far-edge flag
// - X-first row, far, match, X: stop
// - Z-first: enable Z every dwell end unless matched
// - Z-first Z match: flip Z, enable X
// - Z-first X unmatched: back to Z
// - Z-first X match: flip X, row flag, Z
// - Z-first Z match with row: Y, then Z
// - Enables OR runs; direction ORs enabled directions
// - Three flip-flops per axis define sequence
// - Any set run clears other runs
// - Dwell end pulse ends at motor clock
module tasp_programmer
  import tasp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Scan order selection
  input wire logic i_order_xfirst,
  input wire logic i_order_zfirst,
  // Commands and timing pins
  input wire logic i_preset_positive_cmd,
  input wire logic i_match,
  input wire logic i_dwell_expired,
  input wire logic i_motor_clk,
  input wire logic i_depth_sweep_done,
  // Motor control outputs
  output logic o_x_enable,
  output logic o_y_enable,
  output logic o_z_enable,
  output logic o_direction,
  output logic o_stop,
  // Status
  output logic o_dwell_end_pulse,
  output logic o_row_step,
  output logic o_far_edge
);
  tasp_axis_if ax_x ();
  tasp_axis_if ax_y ();
  tasp_axis_if ax_z ();

  logic xf_lvl, zf_lvl, pre_lvl, match_lvl, sweep_done_lvl;
  logic dwell_rise, mclk_rise;
  logic dwell_end_pulse_q, dwell_end_pulse_d;
  logic row_q, row_d;
  logic far_q, far_d;
  logic stop_q, stop_d;
  logic xe_q, ye_q, ze_q, dir_q, dir_d;
  logic step;
  logic sx_l, sx_u, sy_l, sy_u, sz_l, sz_u;
  logic tx, ty, tz;
  logic xe, ye, ze, xd, yd, zd;
  logic zdone_pend_q, zdone_pend_d;
  tasp_order_t order;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  tasp_edge u_xf (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_pin(i_order_xfirst), .o_level(xf_lvl), .o_rise());
  tasp_edge u_zf (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_pin(i_order_zfirst), .o_level(zf_lvl), .o_rise());
  tasp_edge u_pre (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_pin(i_preset_positive_cmd), .o_level(pre_lvl), .o_rise());
  tasp_edge u_match (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_match),
    .o_level(match_lvl),
    .o_rise()
  );
  tasp_edge u_sweep_done (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_depth_sweep_done),
    .o_level(sweep_done_lvl),
    .o_rise()
  );
  tasp_edge u_dwell (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_dwell_expired),
    .o_level(),
    .o_rise(dwell_rise)
  );
  tasp_edge u_mclk (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_motor_clk),
    .o_level(),
    .o_rise(mclk_rise)
  );

  // ----------------------------------------
  // Axes
  // ----------------------------------------
  tasp_axis u_ax_x (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_step(step), .ax(ax_x.axis));
  tasp_axis u_ax_y (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_step(step), .ax(ax_y.axis));
  tasp_axis u_ax_z (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_step(step), .ax(ax_z.axis));

  assign xe = ax_x.enable;
  assign ye = ax_y.enable;
  assign ze = ax_z.enable;
  assign xd = ax_x.dir_q;
  assign yd = ax_y.dir_q;
  assign zd = ax_z.dir_q;

  // Both or neither selected means idle; sequencing stays frozen
  always_comb begin
    order = TASP_ORDER_NONE;
    if (xf_lvl && !zf_lvl) begin
      order = TASP_ORDER_XFIRST;
    end else if (zf_lvl && !xf_lvl) begin
      order = TASP_ORDER_ZFIRST;
    end
  end

  // Work happens on the leading edge of the dwell end pulse only
  assign step = dwell_rise && (order != TASP_ORDER_NONE) && !stop_q;

  // ----------------------------------------
  // Next-run decision per order
  // ----------------------------------------
  always_comb begin
    logic gx, gy, gz;
    gx = 1'h0;
    gy = 1'h0;
    gz = 1'h0;
    tx = 1'h0;
    ty = 1'h0;
    tz = 1'h0;
    unique case (order)
      TASP_ORDER_XFIRST: begin
        if (row_q && zdone_pend_q) begin
          gx = 1'h1;
        end else if (ze) begin
          gz = 1'h1;
        end else if (xe && match_lvl && row_q) begin
          gz = 1'h1;
          tx = 1'h1;
        end else if (xe && match_lvl) begin
          tx = 1'h1;
          gy = 1'h1;
        end else if (ye && match_lvl) begin
          ty = 1'h1;
          gx = 1'h1;
        end else begin
          gx = 1'h1;
        end
      end
      TASP_ORDER_ZFIRST: begin
        if (ye) begin
          gz = 1'h1;
        end else if (ze && match_lvl && row_q) begin
          gy = 1'h1;
          tz = 1'h1;
        end else if (ze && match_lvl) begin
          tz = 1'h1;
          gx = 1'h1;
        end else if (xe && match_lvl) begin
          tx = 1'h1;
          gz = 1'h1;
        end else begin
          gz = 1'h1;
        end
      end
      TASP_ORDER_NONE: begin
      end
    endcase
    // Run side follows the direction the axis will move in
    sx_l = gx && !(xd ^ tx);
    sx_u = gx && (xd ^ tx);
    sy_l = gy && !(yd ^ ty);
    sy_u = gy && (yd ^ ty);
    sz_l = gz && !(zd ^ tz);
    sz_u = gz && (zd ^ tz);
  end

  always_comb begin
    ax_x.set_lower = sx_l;
    ax_x.set_upper = sx_u;
    ax_y.set_lower = sy_l;
    ax_y.set_upper = sy_u;
    ax_z.set_lower = sz_l;
    ax_z.set_upper = sz_u;
    ax_x.toggle_dir = tx;
    ax_y.toggle_dir = ty;
    ax_z.toggle_dir = tz;
    ax_x.preset_dir = pre_lvl;
    ax_y.preset_dir = pre_lvl;
    ax_z.preset_dir = pre_lvl;
    // Another axis running clears this one outside the dwell end
    ax_x.clear_run = !dwell_end_pulse_q && (ye || ze);
    ax_y.clear_run = !dwell_end_pulse_q && (xe || ze);
    ax_z.clear_run = !dwell_end_pulse_q && (xe || ye);
  end

  // ----------------------------------------
  // Flags, stop and dwell end pulse
  // ----------------------------------------
  always_comb begin
    dwell_end_pulse_d = dwell_end_pulse_q;
    row_d = row_q;
    far_d = far_q;
    stop_d = stop_q;
    zdone_pend_d = zdone_pend_q;
    if (dwell_rise) begin
      dwell_end_pulse_d = 1'h1;
    end else if (mclk_rise) begin
      dwell_end_pulse_d = 1'h0;
    end
    // Sweep done may arrive between dwell ends; hold it for the next
    if (sweep_done_lvl && ze) begin
      zdone_pend_d = 1'h1;
    end
    if (step) begin
      unique case (order)
        TASP_ORDER_XFIRST: begin
          if (row_q && far_q && match_lvl && xe) begin
            stop_d = 1'h1;
          end
          if (row_q && zdone_pend_q) begin
            row_d = 1'h0;
            zdone_pend_d = 1'h0;
          end else if (ye && match_lvl) begin
            row_d = 1'h1;
          end
          if (ze && match_lvl && zd) begin
            far_d = 1'h1;
          end
        end
        TASP_ORDER_ZFIRST: begin
          if (row_q && far_q && match_lvl && ze) begin
            stop_d = 1'h1;
          end
          if (ye) begin
            row_d = 1'h0;
          end else if (xe && match_lvl) begin
            row_d = 1'h1;
          end
          if (ye && match_lvl && yd) begin
            far_d = 1'h1;
          end
        end
        TASP_ORDER_NONE: begin
        end
      endcase
    end
  end

  // Direction line is the OR of each enabled axis' direction
  always_comb begin
    dir_d = (xe & xd) | (ye & yd) | (ze & zd);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dwell_end_pulse_q <= TASP_FLAG_RST;
      row_q <= TASP_FLAG_RST;
      far_q <= TASP_FLAG_RST;
      stop_q <= TASP_FLAG_RST;
      zdone_pend_q <= TASP_FLAG_RST;
      xe_q <= TASP_RUN_RST;
      ye_q <= TASP_RUN_RST;
      ze_q <= TASP_RUN_RST;
      dir_q <= TASP_FLAG_RST;
    end else begin
      dwell_end_pulse_q <= dwell_end_pulse_d;
      row_q <= row_d;
      far_q <= far_d;
      stop_q <= stop_d;
      zdone_pend_q <= zdone_pend_d;
      xe_q <= xe;
      ye_q <= ye;
      ze_q <= ze;
      dir_q <= dir_d;
    end
  end

  assign o_x_enable = xe_q;
  assign o_y_enable = ye_q;
  assign o_z_enable = ze_q;
  assign o_direction = dir_q;
  assign o_stop = stop_q;
  assign o_dwell_end_pulse = dwell_end_pulse_q;
  assign o_row_step = row_q;
  assign o_far_edge = far_q;
endmodule

// file: dv/tasp_sva.sv
`timescale 1ns/1ns
module tasp_sva (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Timing pins
  input wire logic i_dwell_expired,
  input wire logic i_motor_clk,
  // Outputs watched
  input wire logic o_x_enable,
  input wire logic o_y_enable,
  input wire logic o_z_enable,
  input wire logic o_direction,
  input wire logic o_stop,
  input wire logic o_dwell_end_pulse,
  input wire logic o_row_step,
  input wire logic o_far_edge
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic [2:0] en;
  assign en = {o_x_enable, o_y_enable, o_z_enable};
  a_one_axis_run: assert property ($onehot0(en))
    else $error("More than one axis enabled");
  a_dir_needs_axis: assert property (o_direction |-> |en)
    else $error("Direction high with no axis enabled");
  a_stop_sticky: assert property (o_stop |=> o_stop)
    else $error("Stop dropped without reset");
  a_enable_at_dwell: assert property (
    $changed(en) |->
    $past(o_dwell_end_pulse) && !$past(o_dwell_end_pulse, 2))
    else $error("Enables moved outside a dwell end");
  a_flag_at_dwell: assert property (
    $changed({o_row_step, o_far_edge}) |-> $rose(o_dwell_end_pulse))
    else $error("Flags moved outside a dwell end");
  a_pulse_cause: assert property (
    $rose(o_dwell_end_pulse) |-> $past(i_dwell_expired, 2))
    else $error("Dwell end pulse without expiry");
  a_pulse_ends: assert property (
    $rose(i_motor_clk) && o_dwell_end_pulse |-> ##[1:4] !o_dwell_end_pulse)
    else $error("Dwell end pulse outlived motor clock");
  a_stop_freeze: assert property ($past(o_stop, 2) |-> $stable(en))
    else $error("Enables moved after stop");
  a_reset_clear: assert property ($fell(i_sys_rst) |->
    !(|en) && !o_stop && !o_row_step && !o_far_edge && !o_direction)
    else $error("Outputs not cleared by reset");
endmodule

// file: dv/tasp_motor_model.sv
`timescale 1ns/1ns
module tasp_motor_model (
  // Clock
  input wire logic i_clk,
  // Bench control
  input wire logic i_req,
  input wire logic i_slow,
  // From programmer
  input wire logic i_dwell_end_pulse,
  // To programmer
  output logic o_dwell_expired = 1'h0,
  output logic o_motor_clk = 1'h0
);
  // ----------------------------------------
  // Dwell timer and motor clock
  // ----------------------------------------
  // Motor clock stands still outside a dwell frame
  int cnt = 0;
  logic armed = 1'h1;
  always @(posedge i_clk) begin
    o_motor_clk <= 1'h0;
    if (!i_req) armed <= 1'h1;
    if (i_req && armed && !o_dwell_expired) begin
      o_dwell_expired <= 1'h1;
      armed <= 1'h0;
    end
    if (i_dwell_end_pulse) begin
      cnt <= cnt + 1;
      if (cnt == (i_slow ? 6 : 1)) begin
        o_motor_clk <= 1'h1;
        o_dwell_expired <= 1'h0;
      end
    end else cnt <= 0;
  end
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, rst, ord_x, ord_z, preset, match, sweep, req, slow;
  logic dwell, mclk, x_en, y_en, z_en, dir, stop, dpulse, row, far;
  int fails = 0;
  int n_compared = 0;
  tasp_programmer dut (.i_clk(clk), .i_sys_rst(rst),
    .i_order_xfirst(ord_x), .i_order_zfirst(ord_z),
    .i_preset_positive_cmd(preset), .i_match(match),
    .i_dwell_expired(dwell), .i_motor_clk(mclk),
    .i_depth_sweep_done(sweep), .o_x_enable(x_en), .o_y_enable(y_en),
    .o_z_enable(z_en), .o_direction(dir), .o_stop(stop),
    .o_dwell_end_pulse(dpulse), .o_row_step(row), .o_far_edge(far));
  tasp_motor_model u_motor (.i_clk(clk), .i_req(req), .i_slow(slow),
    .i_dwell_end_pulse(dpulse), .o_dwell_expired(dwell),
    .o_motor_clk(mclk));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(string what, logic [6:0] exp, logic [6:0] got,
                       logic [6:0] care);
    n_compared++;
    if ((got & care) !== (exp & care)) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp & care,
               got & care);
    end
  endtask
  task automatic clear(logic [1:0] ord);
    @(negedge clk);
    rst = 1'h1;
    preset = 1'h1;
    {ord_x, ord_z} = ord;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    preset = 1'h0;
    repeat (4) @(negedge clk);
  endtask
  // One dwell cycle; state is {stop,x,y,z,dir,row,far}
  task automatic step(logic m, logic sd, logic [6:0] exp, logic [6:0] care);
    int n;
    @(negedge clk);
    match = m;
    sweep = sd;
    req = 1'h1;
    n = 0;
    while (dpulse !== 1'h1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check("dwell_pulse", 7'h01, {6'h00, dpulse}, 7'h01);
    // Enables and direction follow the pulse by one clock
    @(negedge clk);
    check("axis_state", exp, {stop, x_en, y_en, z_en, dir, row, far}, care);
    req = 1'h0;
    n = 0;
    while (dpulse !== 1'h0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {rst, ord_x, ord_z, preset, match, sweep, req, slow} = 8'h80;
    clear(2'h2);
    step(1'h0, 1'h0, 7'h24, 7'h7F);
    step(1'h1, 1'h0, 7'h14, 7'h7F);
    step(1'h0, 1'h0, 7'h20, 7'h7F);
    step(1'h1, 1'h0, 7'h14, 7'h7F);
    step(1'h1, 1'h0, 7'h26, 7'h7F);
    step(1'h1, 1'h0, 7'h0E, 7'h0E);
    step(1'h1, 1'h0, 7'h01, 7'h01);
    step(1'h0, 1'h1, 7'h20, 7'h3A);
    step(1'h1, 1'h0, 7'h10, 7'h38);
    step(1'h1, 1'h0, 7'h22, 7'h3A);
    step(1'h1, 1'h0, 7'h40, 7'h40);
    step(1'h1, 1'h0, 7'h4F, 7'h7F);
    $display("Test xfirst done");
    slow = 1'h1;
    clear(2'h1);
    step(1'h0, 1'h0, 7'h0C, 7'h7F);
    step(1'h1, 1'h0, 7'h24, 7'h7F);
    step(1'h0, 1'h0, 7'h08, 7'h7F);
    preset = 1'h1;
    repeat (4) @(negedge clk);
    preset = 1'h0;
    repeat (4) @(negedge clk);
    check("preset_dir", 7'h01, {6'h00, dir}, 7'h01);
    step(1'h1, 1'h0, 7'h24, 7'h7F);
    step(1'h1, 1'h0, 7'h0A, 7'h7F);
    step(1'h1, 1'h0, 7'h16, 7'h7F);
    step(1'h1, 1'h0, 7'h09, 7'h7B);
    step(1'h1, 1'h0, 7'h20, 7'h7A);
    step(1'h1, 1'h0, 7'h0A, 7'h7A);
    step(1'h1, 1'h0, 7'h40, 7'h40);
    $display("Test zfirst done");
    end_of_test();
  end
  // Runs are well under 10 us; the limit leaves ample margin
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
endmodule
bind tasp_programmer tasp_sva u_sva (.i_clk, .i_sys_rst, .i_dwell_expired,
  .i_motor_clk, .o_x_enable, .o_y_enable, .o_z_enable, .o_direction,
  .o_stop, .o_dwell_end_pulse, .o_row_step, .o_far_edge);
